// >>> dma_ctl_pkg.sv
// What this block does
// - writing start launches a channel; setup checked, ready state if clean
// - entering ready state sets the running flag
// - internal trigger requests the bus straight after ready
// - external trigger waits in ready for its request line
// - trigger-select bit picks internal or external request source
// - normal end when byte count reaches zero, on a width boundary
// - each transfer lowers count by width; non-peripheral addresses step by width if enabled
// - setup error before any data; registers kept; abort and setup-error set
// - error if both peripheral bits, start with done/abort set, or count zero
// - error if count or addresses are not multiples of the width
// - error on illegal transfer width and port width combination
// - bus error ends channel, sets abort and source or dest fault
// - fixed priority, channel 0 highest, channel 3 lowest
// - higher request suspends lower channel, which resumes afterwards
// - channel switch only after holding buffer is written out
// - priority only among channels with the same bus request type
// - normal end sets done flag; interrupt if done enable set
// - abort sets abort flag; interrupt if abort enable set
// - 32-bit holding buffer packs narrow reads and unpacks wide reads
// - all state changes on rising system clock edges
//
// Purpose: constants for the four channel transfer controller
// Assumes: 32-bit classic wishbone register bus
// Notes:   one register window of eight words per channel
package dma_ctl_pkg;
  localparam int  NUM_CH       = 4;
  localparam int  WB_AW        = 8;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0; // channel_control_reg, 0x00
  localparam logic [2:0] REG_STAT = 3'h1; // channel_status_reg, 0x04
  localparam logic [2:0] REG_SRC  = 3'h2; // source_addr_reg, 0x08
  localparam logic [2:0] REG_DST  = 3'h3; // dest_addr_reg, 0x0C
  localparam logic [2:0] REG_CNT  = 3'h4; // byte_count_reg, 0x10
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int C_START = 0;
  localparam int C_EXT   = 1; // external_trigger_select
  localparam int C_SPER  = 2; // source_is_peripheral
  localparam int C_DPER  = 3; // dest_is_peripheral
  localparam int C_TW    = 4; // transfer_width, 2 bits
  localparam int C_PW    = 6; // peripheral_port_width, 2 bits
  localparam int C_SINC  = 8;
  localparam int C_DINC  = 9;
  localparam int C_DIE   = 10; // done_irq_enable
  localparam int C_AIE   = 11; // abort_irq_enable
  localparam int C_RTYP  = 12; // 0 type a, 1 type b
  localparam logic [12:0] CTRL_RST = 13'h0000;
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int S_RUN  = 0;
  localparam int S_DONE = 1;
  localparam int S_ABRT = 2;
  localparam int S_CONF = 3;
  localparam int S_BES  = 4; // source_bus_fault
  localparam int S_BED  = 5; // dest_bus_fault
  localparam logic [5:0] STAT_RST = 6'h00;
  // width codes: 0x is 32 bits, 10 is 16 bits, 11 is 8 bits
  localparam logic [1:0] W16 = 2'h2;
  localparam logic [1:0] W8  = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } eng_state_t;
endpackage : dma_ctl_pkg

// >>> dma_channel_control.sv
// Purpose: four channel dual-address transfer controller channel logic
// Assumes: system bus slave answers each request with ack or err
// Notes:   registers over classic wishbone, one clock domain
`timescale 1ns/10ps
module dma_channel_control #(
  parameter int CH = dma_ctl_pkg::NUM_CH
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [dma_ctl_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic [CH-1:0]                external_transfer_request_n_i,
  output logic      [CH-1:0]                channel_irq_o,
  output logic                              bm_req_o,
  output logic                              bm_we_o,
  output logic      [31:0]                  bm_addr_o,
  output logic      [1:0]                   bm_size_o,
  output logic      [31:0]                  bm_wdata_o,
  input  wire logic [31:0]                  bm_rdata_i,
  input  wire logic                         bm_ack_i,
  input  wire logic                         bm_err_i
);
  import dma_ctl_pkg::*;

  if (CH != NUM_CH) begin : g_chk
    $error("channel count must be four");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] bytes_of(input logic [1:0] code);
    case (code)
      W16:     bytes_of = 3'h2;
      W8:      bytes_of = 3'h1;
      default: bytes_of = 3'h4;
    endcase
  endfunction : bytes_of

  function automatic logic [1:0] first_of(input logic [3:0] v);
    first_of = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : first_of

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [12:0] ctrl [CH];
  logic [5:0]  stat [CH];
  logic [31:0] sar  [CH];
  logic [31:0] dar  [CH];
  logic [31:0] bcr  [CH];
  logic [CH-1:0] pend;
  eng_state_t  state;
  logic [1:0]  cur;
  logic [1:0]  beat;
  logic [31:0] hold; // holding_buffer
  logic        turn;
  logic        xfer_done;
  logic        err_src;
  logic        err_dst;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [1:0]  a_ch     = wb_adr_i[6:5];
  wire [2:0]  a_reg    = wb_adr_i[4:2];
  wire        a_ok     = (wb_adr_i[7] == 1'b0) && (a_reg <= REG_CNT);
  wire        wr       = wb_hit & wb_we_i & a_ok;
  wire [31:0] bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                          {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] rd_ctrl  = {19'h0, ctrl[a_ch]};
  wire [31:0] rd_stat  = {26'h0, stat[a_ch]};
  wire [31:0] rd_mux   = !a_ok ? 32'h0 :
                         (a_reg == REG_CTRL) ? rd_ctrl :
                         (a_reg == REG_STAT) ? rd_stat :
                         (a_reg == REG_SRC)  ? sar[a_ch] :
                         (a_reg == REG_DST)  ? dar[a_ch] : bcr[a_ch];

  // ---------------------------------------------------------------
  // current channel transfer geometry
  // ---------------------------------------------------------------
  wire [12:0] cc      = ctrl[cur];
  wire [2:0]  tw      = bytes_of(cc[C_TW +: 2]);
  wire [2:0]  pw      = bytes_of(cc[C_PW +: 2]);
  wire [2:0]  rsz     = cc[C_SPER] ? pw : tw;
  wire [2:0]  wsz     = cc[C_DPER] ? pw : tw;
  wire [1:0]  rlast   = 2'((tw / rsz) - 3'h1);
  wire [1:0]  wlast   = 2'((tw / wsz) - 3'h1);
  wire [4:0]  roff    = 5'({beat, 3'h0} * rsz);
  wire [4:0]  woff_n  = 5'({2'(beat + 2'h1), 3'h0} * wsz);
  wire [3:0]  rbm     = 4'((4'h1 << rsz) - 4'h1) << roff[4:3];
  wire [31:0] rmask   = {{8{rbm[3]}}, {8{rbm[2]}}, {8{rbm[1]}}, {8{rbm[0]}}};
  // pack read data into its byte lanes of the holding buffer
  wire [31:0] next_hold = (hold & ~rmask) | ((bm_rdata_i << roff) & rmask);

  // ---------------------------------------------------------------
  // request and arbitration
  // ---------------------------------------------------------------
  logic [CH-1:0] want;
  logic [CH-1:0] type_b;
  for (genvar i = 0; i < CH; i++) begin : g_want
    // internal trigger asks at once, external waits for pend
    assign want[i]   = stat[i][S_RUN] & (~ctrl[i][C_EXT] | pend[i]);
    assign type_b[i] = ctrl[i][C_RTYP];
  end

  // each request type ranked on its own, types alternate
  wire [CH-1:0] want_a   = want & ~type_b;
  wire [CH-1:0] want_b   = want & type_b;
  wire          pick_b   = (want_b != '0) & ((want_a == '0) | turn);
  wire [1:0]    grant    = first_of(pick_b ? want_b : want_a);
  wire          any_want = (want != '0);

  // ---------------------------------------------------------------
  // transfer engine, one transfer read then written
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ST_IDLE;
      cur        <= 2'h0;
      beat       <= 2'h0;
      hold       <= 32'h0;
      turn       <= 1'b0;
      bm_req_o   <= 1'b0;
      bm_we_o    <= 1'b0;
      bm_addr_o  <= 32'h0;
      bm_size_o  <= 2'h0;
      bm_wdata_o <= 32'h0;
      xfer_done  <= 1'b0;
      err_src    <= 1'b0;
      err_dst    <= 1'b0;
    end else if (ce_i) begin
      xfer_done <= 1'b0;
      err_src   <= 1'b0;
      err_dst   <= 1'b0;
      case (state)
        ST_IDLE: begin
          // a new grant only between whole transfers
          // and not while a faulted channel still shows running
          if (any_want && !xfer_done && !err_src && !err_dst) begin
            cur       <= grant;
            turn      <= ~pick_b;
            beat      <= 2'h0;
            bm_req_o  <= 1'b1;
            bm_we_o   <= 1'b0;
            bm_addr_o <= sar[grant];
            bm_size_o <= 2'(bytes_of(ctrl[grant][C_SPER] ? ctrl[grant][C_PW +: 2]
                                                         : ctrl[grant][C_TW +: 2]) - 3'h1);
            state     <= ST_READ;
          end
        end
        ST_READ: begin
          if (bm_err_i) begin
            bm_req_o <= 1'b0;
            err_src  <= 1'b1;
            state    <= ST_IDLE;
          end else if (bm_ack_i) begin
            hold <= next_hold;
            if (beat == rlast) begin
              beat       <= 2'h0;
              bm_we_o    <= 1'b1;
              bm_addr_o  <= dar[cur];
              bm_size_o  <= 2'(wsz - 3'h1);
              bm_wdata_o <= next_hold; // unpack starts at lane 0
              state      <= ST_WRITE;
            end else begin
              beat <= 2'(beat + 2'h1);
            end
          end
        end
        ST_WRITE: begin
          if (bm_err_i) begin
            bm_req_o <= 1'b0;
            err_dst  <= 1'b1;
            state    <= ST_IDLE;
          end else if (bm_ack_i) begin
            if (beat == wlast) begin
              bm_req_o  <= 1'b0;
              xfer_done <= 1'b1; // buffer empty, switch allowed
              state     <= ST_IDLE;
            end else begin
              beat       <= 2'(beat + 2'h1);
              bm_wdata_o <= hold >> woff_n;
            end
          end
        end
        default: begin
          bm_req_o <= 1'b0;
          state    <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // per channel registers
  // ---------------------------------------------------------------
  for (genvar i = 0; i < CH; i++) begin : g_ch
    wire        sel_me  = wr & (a_ch == 2'(i));
    wire        w_ctrl  = sel_me & (a_reg == REG_CTRL);
    wire        w_stat  = sel_me & (a_reg == REG_STAT);
    wire [31:0] n_ctrl  = ({19'h0, ctrl[i]} & ~bmask) | (wb_dat_i & bmask);
    wire [2:0]  ntw     = bytes_of(n_ctrl[C_TW +: 2]);
    wire [2:0]  npw     = bytes_of(n_ctrl[C_PW +: 2]);
    wire [1:0]  amsk    = 2'(ntw - 3'h1);
    wire        go      = w_ctrl & n_ctrl[C_START] & ~stat[i][S_RUN];
    // setup checks on start
    wire        bad     = (n_ctrl[C_SPER] & n_ctrl[C_DPER])
                        | stat[i][S_DONE] | stat[i][S_ABRT]
                        | (bcr[i] == 32'h0)
                        | ((bcr[i][1:0] & amsk) != 2'h0)
                        | ((sar[i][1:0] & amsk) != 2'h0)
                        | ((dar[i][1:0] & amsk) != 2'h0)
                        | (npw > ntw);
    wire        mine    = (cur == 2'(i));
    wire        step    = xfer_done & mine;
    wire        last    = step & (bcr[i] == 32'(tw));
    wire        e_src   = err_src & mine;
    wire        e_dst   = err_dst & mine;
    wire        per_io  = ctrl[i][C_SPER] | ctrl[i][C_DPER];
    wire [5:0]  clr     = (w_stat ? wb_dat_i[5:0] & bmask[5:0] : 6'h0) & 6'h3E;

    // control and status; hardware set wins over software clear
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ctrl[i] <= CTRL_RST;
        stat[i] <= STAT_RST;
      end else if (ce_i) begin
        if (w_ctrl)
          ctrl[i] <= {n_ctrl[12:1], 1'b0};
        stat[i] <= stat[i] & ~clr;
        if (go && bad) begin
          stat[i][S_ABRT] <= 1'b1;
          stat[i][S_CONF] <= 1'b1;
        end else if (go) begin
          stat[i][S_RUN] <= 1'b1;
        end
        if (last) begin
          stat[i][S_RUN]  <= 1'b0;
          stat[i][S_DONE] <= 1'b1;
        end
        if (e_src || e_dst) begin
          stat[i][S_RUN]  <= 1'b0;
          stat[i][S_ABRT] <= 1'b1;
          stat[i][S_BES]  <= stat[i][S_BES] | e_src;
          stat[i][S_BED]  <= stat[i][S_BED] | e_dst;
        end
      end
    end

    // count and addresses; untouched by a failed start
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sar[i] <= 32'h0;
        dar[i] <= 32'h0;
        bcr[i] <= 32'h0;
      end else if (ce_i) begin
        if (step) begin
          bcr[i] <= bcr[i] - 32'(tw);
          if (ctrl[i][C_SINC] && !ctrl[i][C_SPER])
            sar[i] <= sar[i] + 32'(tw);
          if (ctrl[i][C_DINC] && !ctrl[i][C_DPER])
            dar[i] <= dar[i] + 32'(tw);
        end else begin
          if (sel_me && a_reg == REG_SRC)
            sar[i] <= (sar[i] & ~bmask) | (wb_dat_i & bmask);
          if (sel_me && a_reg == REG_DST)
            dar[i] <= (dar[i] & ~bmask) | (wb_dat_i & bmask);
          if (sel_me && a_reg == REG_CNT)
            bcr[i] <= (bcr[i] & ~bmask) | (wb_dat_i & bmask);
        end
      end
    end

    // external request held while ready
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pend[i] <= 1'b0;
      end else if (ce_i) begin
        if (!stat[i][S_RUN] || last || e_src || e_dst)
          pend[i] <= 1'b0;
        else if (ctrl[i][C_EXT] && !external_transfer_request_n_i[i])
          pend[i] <= 1'b1;
        else if (step && per_io)
          pend[i] <= 1'b0; // one transfer per peripheral request
      end
    end

    // interrupt level from flags and enables
    always_ff @(posedge clk_i) begin
      if (rst_i)
        channel_irq_o[i] <= 1'b0;
      else if (ce_i)
        channel_irq_o[i] <= (stat[i][S_DONE] & ctrl[i][C_DIE])
                          | (stat[i][S_ABRT] & ctrl[i][C_AIE]);
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer, one wait state, unmapped reads zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_mux : 32'h0;
    end
  end
endmodule : dma_channel_control

// >>> dma_ctl_chk.sv
// Purpose: port-level checks on the transfer controller
// Assumes: ce_i held high by the bench
// Notes:   bound to every dma_channel_control instance
`timescale 1ns/10ps
module dma_ctl_chk #(
  parameter int CH = 4
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          ce_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic [31:0]   wb_dat_o,
  input wire logic [CH-1:0] channel_irq_o,
  input wire logic          bm_req_o,
  input wire logic          bm_we_o,
  input wire logic [31:0]   bm_addr_o,
  input wire logic [1:0]    bm_size_o,
  input wire logic          bm_ack_i,
  input wire logic          bm_err_i
);
  // ---------------------------------------------------------------
  // bus beat sequences and checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_beat_done;
    bm_req_o && !bm_we_o && bm_ack_i;
  endsequence
  sequence wr_beat_done;
    bm_req_o && bm_we_o && bm_ack_i;
  endsequence
  wb_ack_next_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register ack missing");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack too long");
  wb_dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  bm_req_hold_a: assert property (bm_req_o && !bm_ack_i && !bm_err_i |=>
    bm_req_o && $stable(bm_addr_o) && $stable(bm_we_o) && $stable(bm_size_o))
    else $error("bus request changed before answer");
  read_then_beat_a: assert property (rd_beat_done |=> bm_req_o)
    else $error("no beat after read");
  write_then_gap_a: assert property (wr_beat_done |=> !bm_req_o || (bm_we_o && $stable(bm_addr_o)))
    else $error("read follows a write beat");
  err_stops_a: assert property (bm_req_o && bm_err_i |=> !bm_req_o)
    else $error("request kept after bus error");
  read_first_a: assert property ($rose(bm_req_o) |-> !bm_we_o)
    else $error("transfer began with a write");
  size_legal_a: assert property (bm_req_o |-> bm_size_o != 2'h2)
    else $error("illegal beat size");
  beat_aligned_a: assert property (bm_req_o |-> (bm_size_o != 2'h3 || bm_addr_o[1:0] == 2'h0)
    && (bm_size_o != 2'h1 || !bm_addr_o[0])) else $error("misaligned beat");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !bm_req_o && !wb_ack_o
    && channel_irq_o == '0) else $error("outputs active after reset");
endmodule : dma_ctl_chk

bind dma_channel_control dma_ctl_chk #(.CH(CH)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .channel_irq_o(channel_irq_o), .bm_req_o(bm_req_o), .bm_we_o(bm_we_o), .bm_addr_o(bm_addr_o),
  .bm_size_o(bm_size_o), .bm_ack_i(bm_ack_i), .bm_err_i(bm_err_i));

// >>> bus_slave_model.sv
// Purpose: system bus slave with word memory and byte peripheral
// Assumes: one request at a time, held until ack or err
// Notes:   slow_i adds three wait states; err_a answers with err
`timescale 1ns/10ps
module bus_slave_model #(
  parameter logic [31:0] ERR_A = 32'h000000F0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             ack_o,
  output logic             err_o
);
  logic [31:0] mem [64];
  logic [31:0] rd_q;
  logic [31:0] mask;
  logic [7:0]  pbyte;
  logic [1:0]  wait_n;
  // read data valid only with ack, inverted otherwise
  assign rdata_o = ack_o ? rd_q : ~rd_q;
  assign mask    = (size_i == 2'h0) ? 32'hFF : (size_i == 2'h1) ? 32'hFFFF : 32'hFFFFFFFF;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'hC0DE0000 + i;
  end
  // one answer per request; byte reads come from a counting port
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    if (rst_i) begin
      wait_n <= 2'h0;
      pbyte  <= 8'hA0;
    end else if (req_i && !ack_o && !err_o) begin
      wait_n <= (slow_i && wait_n != 2'h3) ? wait_n + 2'h1 : 2'h0;
      if (!slow_i || wait_n == 2'h3) begin
        err_o <= (addr_i == ERR_A);
        ack_o <= (addr_i != ERR_A);
        if (we_i && addr_i != ERR_A) mem[addr_i[7:2]] <= wdata_i & mask;
        rd_q <= (size_i == 2'h0) ? {24'h0, pbyte} : mem[addr_i[7:2]];
        if (!we_i && size_i == 2'h0) pbyte <= pbyte + 8'h1;
      end
    end
  end
endmodule : bus_slave_model

// >>> tb_top.sv
// Purpose: register-level tests of the transfer controller
// Assumes: ce_i held high; slave model behind the system bus
// Notes:   transfer widths and port widths never illegal unless tested
`timescale 1ns/10ps
module tb_top;
  import dma_ctl_pkg::*;
  logic        clk_i, rst_i, ce_i, cyc, stb, we, ack, slow, bm_req, bm_we, bm_ack, bm_err;
  logic [7:0]  adr;
  logic [3:0]  sel, req_n, irq;
  logic [1:0]  bm_size;
  logic [31:0] wdat, rdat, q, bm_addr, bm_wdata, bm_rdata;
  int          err_count, total_checks;
  localparam logic [31:0] ST = 32'h1 << C_START, EXT = 32'h1 << C_EXT, SP = 32'h1 << C_SPER;
  localparam logic [31:0] DP = 32'h1 << C_DPER, STEP = (32'h1 << C_SINC) | (32'h1 << C_DINC);
  localparam logic [31:0] FD = 32'h1 << S_DONE, FA = 32'h1 << S_ABRT, FC = 32'h1 << S_CONF;
  localparam logic [31:0] RUN = 32'h1 << S_RUN, FBS = 32'h1 << S_BES;
  logic [31:0] ectl [5] = '{ST | SP | DP, ST, ST, ST, ST | (32'(W16) << C_TW)};
  logic [31:0] ecnt [5] = '{32'h8, 32'h0, 32'h6, 32'h8, 32'h8};
  logic [31:0] esrc [5] = '{32'h10, 32'h10, 32'h10, 32'h12, 32'h10};
  // ---------------------------------------------------------------
  // design, slave and clock
  // ---------------------------------------------------------------
  dma_channel_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_transfer_request_n_i(req_n), .channel_irq_o(irq), .bm_req_o(bm_req), .bm_we_o(bm_we),
    .bm_addr_o(bm_addr), .bm_size_o(bm_size), .bm_wdata_o(bm_wdata), .bm_rdata_i(bm_rdata),
    .bm_ack_i(bm_ack), .bm_err_i(bm_err));
  bus_slave_model u_slave (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .req_i(bm_req), .we_i(bm_we),
    .addr_i(bm_addr), .size_i(bm_size), .wdata_i(bm_wdata), .rdata_o(bm_rdata), .ack_o(bm_ack),
    .err_o(bm_err));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // register address of channel c, register r
  function automatic logic [7:0] ra(input int c, input logic [2:0] r);
    return {1'b0, c[1:0], r, 2'b00};
  endfunction : ra
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // classic single wishbone cycle, held until ack
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 50) chk("register ack", 32'h1, 32'h0);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    acc(a, 1'b1, d, t);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    acc(a, 1'b0, 32'h0, t);
    chk(nm, exp, t);
  endtask : rd_chk
  task automatic setup(input int c, input logic [31:0] s, d, n, ctl);
    wr(ra(c, REG_SRC), s);
    wr(ra(c, REG_DST), d);
    wr(ra(c, REG_CNT), n);
    wr(ra(c, REG_CTRL), ctl);
  endtask : setup
  // poll the running flag under a bound
  task automatic wait_stop(input int c);
    int n;
    n = 0;
    do begin
      acc(ra(c, REG_STAT), 1'b0, 32'h0, q);
      n++;
    end while (q[S_RUN] !== 1'b0 && n < 100);
    if (n >= 100) chk("channel stop", 32'h0, 32'h1);
  endtask : wait_stop
  // pull request lines low, held until the bus is requested
  task automatic fire(input logic [3:0] m);
    int n;
    @(posedge clk_i);
    req_n <= ~m;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (bm_req !== 1'b1 && n < 100);
    q = bm_addr;
    req_n <= 4'hF;
    if (n >= 100) chk("bus request", 32'h1, 32'h0);
  endtask : fire
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #100us;
    err_count++;
    $display("mismatch watchdog expected finish seen timeout");
    complete_run();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_i, ce_i, cyc, stb, we, slow, adr, sel, wdat, req_n} = {6'b110000, 8'h0, 4'h0, 32'h0, 4'hF};
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", ra(0, REG_CTRL), 32'h0);
    rd_chk("stat reset", ra(3, REG_STAT), 32'h0);
    rd_chk("unmapped", 8'h80, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      setup(0, esrc[i], 32'h40, ecnt[i], ectl[i]);
      rd_chk("conf stat", ra(0, REG_STAT), FA | FC);
      rd_chk("conf count", ra(0, REG_CNT), ecnt[i]);
      rd_chk("conf src", ra(0, REG_SRC), esrc[i]);
      wr(ra(0, REG_STAT), 32'h3E);
    end
    rd_chk("stat cleared", ra(0, REG_STAT), 32'h0);
    $display("test setup errors done");
    slow <= 1'b1;
    setup(0, 32'h10, 32'h40, 32'h8, ST | STEP | (32'h1 << C_DIE));
    rd_chk("running", ra(0, REG_STAT), RUN);
    wait_stop(0);
    rd_chk("done stat", ra(0, REG_STAT), FD);
    rd_chk("count end", ra(0, REG_CNT), 32'h0);
    rd_chk("src step", ra(0, REG_SRC), 32'h18);
    rd_chk("dst step", ra(0, REG_DST), 32'h48);
    chk("copy word 0", 32'hC0DE0004, u_slave.mem[16]);
    chk("copy word 1", 32'hC0DE0005, u_slave.mem[17]);
    chk("done irq", 32'h1, {28'h0, irq});
    wr(ra(0, REG_CTRL), ST | STEP | (32'h1 << C_DIE));
    rd_chk("restart done set", ra(0, REG_STAT), FD | FA | FC);
    wr(ra(0, REG_STAT), 32'h3E);
    @(posedge clk_i); // irq register follows the cleared flag one edge later
    chk("irq cleared", 32'h0, {28'h0, irq});
    $display("test memory copy done");
    slow <= 1'b0;
    setup(1, 32'h20, 32'h60, 32'h4, ST | EXT | SP | (32'h1 << C_DINC) | (32'(W8) << C_PW));
    repeat (10) @(posedge clk_i);
    chk("ext waits", 32'h0, {31'h0, bm_req});
    rd_chk("ext ready", ra(1, REG_STAT), RUN);
    fire(4'h2);
    wait_stop(1);
    chk("packed word", 32'hA3A2A1A0, u_slave.mem[24]);
    rd_chk("pack done", ra(1, REG_STAT), FD);
    setup(2, 32'h10, 32'h24, 32'h4, ST | EXT | DP | (32'h1 << C_SINC) | (32'(W16) << C_PW));
    fire(4'h4);
    wait_stop(2);
    chk("unpacked half", 32'h0000C0DE, u_slave.mem[9]);
    $display("test packing done");
    setup(3, 32'hF0, 32'h90, 32'h4, ST | (32'h1 << C_AIE));
    wait_stop(3);
    rd_chk("bus fault stat", ra(3, REG_STAT), FA | FBS);
    chk("abort irq", 32'h8, {28'h0, irq});
    $display("test bus error done");
    for (int c = 0; c < 4; c++) wr(ra(c, REG_STAT), 32'h3E);
    setup(1, 32'h30, 32'hA0, 32'h8, ST | EXT | STEP);
    setup(0, 32'h00, 32'h80, 32'h8, ST | EXT | STEP);
    fire(4'h3);
    chk("first served", 32'h0, q);
    wait_stop(1);
    rd_chk("low prio done", ra(1, REG_STAT), FD);
    rd_chk("high prio done", ra(0, REG_STAT), FD);
    $display("test priority done");
    complete_run();
  end
endmodule : tb_top
